// ### adc_sequence_config.sv
// Converter configuration registers, sequencer, clock divider and pin control
//
// Our own choices: register access over Wishbone and the placing of the registers.
module adc_sequence_config #(
   parameter logic [15:0] PRESENT_MASK = 16'h9FFF,
   parameter bit SMALL_VARIANT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic module_disable_i,
   input wire logic rc_tick_i,
   input wire logic sample_start_i,
   input wire logic result_valid_i,
   input wire logic seq_done_i,
   input wire logic [15:0] pin_level_i,
   output logic conv_tick_o,
   output logic sample_end_o,
   output logic seq_event_o,
   output logic [3:0] buf_addr_o,
   output logic [3:0] chan_enable_o,
   output logic sample_b_o,
   output logic [4:0] ch0_pos_o,
   output logic ch0_low_ref_o,
   output logic ch0_neg_o,
   output logic [1:0] ch13_neg_o,
   output logic ch13_pos_o,
   output logic ch23_pos_open_o,
   output logic [2:0] reference_select_o,
   output logic [15:0] port_read_o,
   output logic [15:0] mux_ground_o
);
   import adc_seq_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // Every register, counter and pulse of the block in one word;
   // one process computes the next copy, one registers it
   typedef struct packed {
      logic [15:0] ctl2;
      logic [15:0] ctl3;
      logic [15:0] chs123;
      logic [15:0] chs0;
      logic [15:0] list;
      logic [15:0] pcfg;
      logic ack;
      logic [31:0] rdata;
      logic [7:0] div_cnt;
      logic tick;
      logic samp_busy;
      logic [4:0] samp_cnt;
      logic samp_end;
      logic [3:0] seq_cnt;
      logic half;
      logic [3:0] wr_addr;
      logic use_b;
      logic [3:0] scan_ptr;
      logic restart;
      logic event_p;
      logic [15:0] port_rd;
      logic [15:0] mux_gnd;
   } state_t;

   state_t st_reg;
   state_t st_next;

   // Next selected list entry after ptr, wrapping; ptr 15 gives the first
   // Searches at most sixteen slots; an empty list returns ptr unchanged
   function automatic logic [3:0] next_scan(input logic [15:0] list, input logic [3:0] ptr);
      logic [3:0] res;
      logic found;
      logic [3:0] idx;
      res = ptr;
      found = 1'b0;
      for (int i = 1; i <= 16; i++) begin
         idx = ptr + i[3:0];
         if (!found && list[idx]) begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction : next_scan

   // Byte-lane merge of a write into a 16-bit register
   // Only lanes 0 and 1 carry register bits; upper lanes are ignored
   function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (sel[0]) begin
         v[7:0] = d[7:0];
      end
      if (sel[1]) begin
         v[15:8] = d[15:8];
      end
      return v & mask;
   endfunction : lane_wr

   // ----------------------------------------------------------------
   // Decoded fields
   // ----------------------------------------------------------------
   logic scan_en;
   logic split;
   logic alternate_sampling;
   logic [3:0] spi;
   logic [1:0] chps;
   logic int_clk;
   logic [7:0] div_set;
   logic [4:0] samc;
   logic [15:0] scan_list;
   logic [3:0] scan_cur;
   logic [4:0] ch0_sel;
   logic req;

   // Field extracts of the configuration registers
   assign scan_en = st_reg.ctl2[SCAN_EN_BIT];
   assign split = st_reg.ctl2[SPLIT_BIT];
   assign alternate_sampling = st_reg.ctl2[ALT_BIT];
   assign spi = st_reg.ctl2[SPI_LSB +: 4];
   assign chps = st_reg.ctl2[CHPS_LSB +: 2];
   assign int_clk = st_reg.ctl3[CLK_SRC_BIT];
   assign div_set = st_reg.ctl3[DIV_LSB +: 8];
   assign samc = st_reg.ctl3[SAMC_LSB +: 5];
   // List limited to inputs 0-12 and 15
   // Temperature code 13 is outside the list
   assign scan_list = st_reg.list & MASK_LIST;
   assign scan_cur = st_reg.restart ? next_scan(scan_list, PTR_LAST) : st_reg.scan_ptr;
   assign ch0_sel = st_reg.use_b ? st_reg.chs0[CH0_B_LSB +: 5] : st_reg.chs0[CH0_A_LSB +: 5];
   // Requests are taken only while ack is low
   assign req = cyc_i && stb_i && !st_reg.ack;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.ack = req;
      st_next.tick = 1'b0;
      st_next.samp_end = 1'b0;
      st_next.event_p = 1'b0;

      // ------------------------------------------------------------
      // Register bus
      // ------------------------------------------------------------
      // Bus read and write
      // A held strobe is not re-taken while ack stands, so one request
      // gives exactly one write and one ack pulse
      if (req) begin
         st_next.rdata = 32'h0000_0000;
         unique case (adr_i)
            OFS_CTL2: begin
               st_next.rdata[15:0] = st_reg.ctl2;
               st_next.rdata[FILL_HALF_BIT] = st_reg.half;
               if (we_i) begin
                  st_next.ctl2 = lane_wr(st_reg.ctl2, dat_i, sel_i, MASK_CTL2);
               end
            end
            OFS_CTL3: begin
               st_next.rdata[15:0] = st_reg.ctl3;
               if (we_i) begin
                  st_next.ctl3 = lane_wr(st_reg.ctl3, dat_i, sel_i, MASK_CTL3);
               end
            end
            OFS_CHS123: begin
               st_next.rdata[15:0] = st_reg.chs123;
               if (we_i) begin
                  st_next.chs123 = lane_wr(st_reg.chs123, dat_i, sel_i, MASK_CHS123);
               end
            end
            OFS_CHS0: begin
               st_next.rdata[15:0] = st_reg.chs0;
               if (we_i) begin
                  st_next.chs0 = lane_wr(st_reg.chs0, dat_i, sel_i, MASK_CHS0);
               end
            end
            OFS_SCAN: begin
               st_next.rdata[15:0] = st_reg.list;
               if (we_i) begin
                  st_next.list = lane_wr(st_reg.list, dat_i, sel_i, MASK_LIST);
               end
            end
            OFS_PCFG: begin
               st_next.rdata[15:0] = st_reg.pcfg;
               if (we_i) begin
                  st_next.pcfg = lane_wr(st_reg.pcfg, dat_i, sel_i, MASK_LIST);
               end
            end
            default: begin
               st_next.rdata = 32'h0000_0000;
            end
         endcase
      end

      // ------------------------------------------------------------
      // Conversion clock
      // ------------------------------------------------------------
      // Compare with >= so a smaller divider written mid-count wraps
      // at once instead of running through the whole counter range
      // Divide system clock by field plus one, reserved codes clamp
      if (st_reg.div_cnt >= ((div_set > DIV_MAX) ? DIV_MAX : div_set)) begin
         st_next.div_cnt = 8'h00;
         st_next.tick = 1'b1;
      end else begin
         st_next.div_cnt = st_reg.div_cnt + 8'h01;
      end
      if (int_clk) begin
         st_next.div_cnt = 8'h00;
         st_next.tick = rc_tick_i;
      end

      // ------------------------------------------------------------
      // Sample timer
      // ------------------------------------------------------------
      // A zero count ends the sample two cycles after start
      // A new start reloads the count even while busy
      // Auto-sample time in conversion clock periods
      if (sample_start_i) begin
         st_next.samp_busy = 1'b1;
         st_next.samp_cnt = samc;
      end else if (st_reg.samp_busy) begin
         if (st_reg.samp_cnt == 5'h00) begin
            st_next.samp_busy = 1'b0;
            st_next.samp_end = 1'b1;
         end else if (conv_tick_o) begin
            st_next.samp_cnt = st_reg.samp_cnt - 5'h01;
         end
      end

      // ------------------------------------------------------------
      // Result buffer and sequencer
      // ------------------------------------------------------------
      // An event in the same cycle as a result wins on the address
      // Each result takes the next buffer word
      if (result_valid_i) begin
         st_next.wr_addr = st_reg.wr_addr + 4'h1;
      end

      // Sequence completion: scan step, A/B toggle, event cadence
      // Scan pointer moves only on a sample A sequence, so a sample B
      // sequence never consumes a list entry
      if (seq_done_i) begin
         // Alternate A and B per sequence
         st_next.use_b = alternate_sampling && !st_reg.use_b;
         // Scan advances only after sample A sequences
         if (scan_en && !st_reg.use_b) begin
            st_next.scan_ptr = next_scan(scan_list, scan_cur);
            st_next.restart = 1'b0;
         end
         if (st_reg.seq_cnt >= spi) begin
            st_next.seq_cnt = 4'h0;
            st_next.event_p = 1'b1;
            // Scan list restarts at the event
            st_next.restart = 1'b1;
            // Split mode alternates halves, else restart at zero
            if (split) begin
               st_next.half = !st_reg.half;
               st_next.wr_addr = st_reg.half ? 4'h0 : HALF_BASE;
            end else begin
               st_next.half = 1'b0;
               st_next.wr_addr = 4'h0;
            end
         end else begin
            st_next.seq_cnt = st_reg.seq_cnt + 4'h1;
         end
      end
      if (!alternate_sampling && !seq_done_i) begin
         st_next.use_b = 1'b0;
      end

      // ------------------------------------------------------------
      // Pin configuration
      // ------------------------------------------------------------
      // Port read and mux ground share one register stage, so they
      // never disagree for a cycle
      // Digital pins read through, mux grounded
      // Module disable forces every pin digital
      for (int p = 0; p < 16; p++) begin
         st_next.mux_gnd[p] = module_disable_i || st_reg.pcfg[p];
         st_next.port_rd[p] = st_next.mux_gnd[p] && pin_level_i[p];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // Synchronous reset; configuration returns to zero, so pins come
   // up analog and the scan list restarts at its first entry
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.ctl2 <= RST_REG;
         st_reg.ctl3 <= RST_REG;
         st_reg.chs123 <= RST_REG;
         st_reg.chs0 <= RST_REG;
         st_reg.list <= RST_REG;
         st_reg.pcfg <= RST_REG;
         st_reg.restart <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign dat_o = st_reg.rdata;
   assign ack_o = st_reg.ack;
   assign conv_tick_o = st_reg.tick;
   assign sample_end_o = st_reg.samp_end;
   assign seq_event_o = st_reg.event_p;
   assign buf_addr_o = st_reg.wr_addr;
   assign sample_b_o = st_reg.use_b;
   assign reference_select_o = st_reg.ctl2[REF_LSB +: 3];
   assign port_read_o = st_reg.port_rd;
   assign mux_ground_o = st_reg.mux_gnd;

   // Channel-count decode
   // Codes 10 and 11 both select all four channels
   assign chan_enable_o = chps[1] ? 4'hF : (chps[0] ? 4'h3 : 4'h1);

   // Selections follow sample_b_o, so they change one cycle after
   // the sequence that flips between sample A and sample B
   // Scan replaces sample A positive selection
   assign ch0_pos_o = (scan_en && !st_reg.use_b) ? {1'b0, scan_cur} : ch0_sel;
   // Absent or empty scan slot converts the low reference
   // An empty list leaves the pointer unchanged, at 15 after a restart, which is also caught here
   assign ch0_low_ref_o = scan_en && !st_reg.use_b &&
                          (!PRESENT_MASK[scan_cur] || scan_list == 16'h0000);
   assign ch0_neg_o = st_reg.use_b ? st_reg.chs0[CH0_B_LSB + CH0_NEG_OFS]
                                   : st_reg.chs0[CH0_A_LSB + CH0_NEG_OFS];

   // A and B selectors share one encoding
   // One A/B select feeds every channel 1-3 selector
   assign ch13_neg_o = st_reg.use_b ? st_reg.chs123[NEG_B_LSB +: 2]
                                    : st_reg.chs123[NEG_A_LSB +: 2];
   assign ch13_pos_o = st_reg.use_b ? st_reg.chs123[POS_B_BIT] : st_reg.chs123[POS_A_BIT];
   // Small variant leaves channels 2 and 3 open
   // Larger variants route all three positive inputs; no open flag
   assign ch23_pos_open_o = SMALL_VARIANT && ch13_pos_o;
endmodule : adc_sequence_config

// ### adc_seq_pkg.sv
// Register map, field layout and constants of the converter sequencing control
package adc_seq_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTL2 = 8'h00;
   localparam logic [7:0] OFS_CTL3 = 8'h04;
   localparam logic [7:0] OFS_CHS123 = 8'h08;
   localparam logic [7:0] OFS_CHS0 = 8'h0C;
   localparam logic [7:0] OFS_SCAN = 8'h10;
   localparam logic [7:0] OFS_PCFG = 8'h14;

   // ----------------------------------------------------------------
   // Writable bits and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] MASK_CTL2 = 16'hE73F;
   localparam logic [15:0] MASK_CTL3 = 16'h9FFF;
   localparam logic [15:0] MASK_CHS123 = 16'h0707;
   localparam logic [15:0] MASK_CHS0 = 16'h9F9F;
   localparam logic [15:0] MASK_LIST = 16'h9FFF;
   localparam logic [15:0] RST_REG = 16'h0000;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int REF_LSB = 13;
   localparam int SCAN_EN_BIT = 10;
   localparam int CHPS_LSB = 8;
   localparam int FILL_HALF_BIT = 7;
   localparam int SPI_LSB = 2;
   localparam int SPLIT_BIT = 1;
   localparam int ALT_BIT = 0;
   localparam int CLK_SRC_BIT = 15;
   localparam int SAMC_LSB = 8;
   localparam int DIV_LSB = 0;
   localparam int NEG_B_LSB = 9;
   localparam int POS_B_BIT = 8;
   localparam int NEG_A_LSB = 1;
   localparam int POS_A_BIT = 0;
   localparam int CH0_B_LSB = 8;
   localparam int CH0_A_LSB = 0;
   localparam int CH0_NEG_OFS = 7;

   // ----------------------------------------------------------------
   // Divider, buffer and input codes
   // ----------------------------------------------------------------
   localparam logic [7:0] DIV_MAX = 8'h3F;
   localparam logic [3:0] HALF_BASE = 4'h8;
   localparam logic [4:0] TEMP_CODE = 5'h0D;
   localparam logic [3:0] PTR_LAST = 4'hF;
endpackage : adc_seq_pkg

// ### adc_sequence_config_chk.sv
// Port-level checker for the converter sequencing control
module adc_sequence_config_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic ack_o,
   input wire logic module_disable_i,
   input wire logic result_valid_i,
   input wire logic seq_done_i,
   input wire logic seq_event_o,
   input wire logic [3:0] buf_addr_o,
   input wire logic [3:0] chan_enable_o,
   input wire logic ch13_pos_o,
   input wire logic ch23_pos_open_o,
   input wire logic [15:0] port_read_o,
   input wire logic [15:0] mux_ground_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   ack_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chan_count_a: assert property (chan_enable_o inside {4'h1, 4'h3, 4'hF})
      else $error("bad channel enable set");
   analog_read_a: assert property ((port_read_o & ~mux_ground_o) == 16'h0000)
      else $error("analog pin reads nonzero");
   module_off_a: assert property (module_disable_i |=> mux_ground_o == 16'hFFFF)
      else $error("disabled module left analog pin");
   event_cause_a: assert property (seq_event_o |-> $past(seq_done_i))
      else $error("event without finished sequence");
   event_addr_a: assert property (seq_event_o |-> buf_addr_o inside {4'h0, 4'h8})
      else $error("fill not restarted at event");
   result_step_a: assert property (result_valid_i && !seq_done_i |=>
      buf_addr_o == $past(buf_addr_o) + 4'h1)
      else $error("buffer word not advanced");
   open_pos_a: assert property (ch23_pos_open_o |-> ch13_pos_o)
      else $error("open inputs without positive select");
   // Main scenarios reached
   cover property (seq_event_o);
   cover property (ack_o && we_i);
   cover property (module_disable_i ##1 mux_ground_o == 16'hFFFF);
endmodule : adc_sequence_config_chk

bind adc_sequence_config adc_sequence_config_chk chk_inst (.*);

// ### adc_sequence_config_tb.sv
// Self-checking bench for the converter sequencing control
module adc_sequence_config_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import adc_seq_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic module_disable_i = 1'b0, rc_tick_i = 1'b0, sample_start_i = 1'b0;
   logic result_valid_i = 1'b0, seq_done_i = 1'b0;
   logic [15:0] pin_level_i = 16'hFFFF;
   logic [31:0] dat_o;
   logic ack_o, conv_tick_o, sample_end_o, seq_event_o, sample_b_o, ch0_low_ref_o;
   logic ch0_neg_o, ch13_pos_o, ch23_pos_open_o;
   logic [3:0] buf_addr_o, chan_enable_o;
   logic [4:0] ch0_pos_o;
   logic [1:0] ch13_neg_o;
   logic [2:0] reference_select_o;
   logic [15:0] port_read_o, mux_ground_o, q;
   int n_fail = 0, checked = 0, n_ev = 0, n_tick = 0, n_end = 0;
   // Register rows: address beside the readback of an all-ones write
   logic [7:0] adr_tab [7] = '{OFS_CTL2, OFS_CTL3, OFS_CHS123, OFS_CHS0, OFS_SCAN,
      OFS_PCFG, 8'h18};
   logic [15:0] msk_tab [7] = '{MASK_CTL2, MASK_CTL3, MASK_CHS123, MASK_CHS0,
      MASK_LIST, MASK_LIST, 16'h0000};
   logic [3:0] cnt_tab [4] = '{4'h1, 4'h3, 4'hF, 4'hF};

   adc_sequence_config #(.PRESENT_MASK(16'h001F), .SMALL_VARIANT(1'b1))
      adc_sequence_config_inst (.*);

   // Clock generation
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // Event and tick counters
   always @(posedge clk_i) begin
      if (seq_event_o === 1'b1) n_ev++;
      if (conv_tick_o === 1'b1) n_tick++;
      if (sample_end_o === 1'b1) n_end++;
   end

   // Classic single bus cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h3, 16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o[15:0];
      if (n >= 50) begin
         n_fail++;
         $display("FAIL bus ack expected 1 seen 0");
      end
      {cyc_i, stb_i} <= 2'b00;
   endtask : wb

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_n

   // One-cycle pulse of result or sequence-done
   task automatic pulse(input logic r);
      @(posedge clk_i);
      {result_valid_i, seq_done_i} <= {r, ~r};
      @(posedge clk_i);
      {result_valid_i, seq_done_i} <= 2'b00;
      wait_n(2);
   endtask : pulse

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test

   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      $display("FAIL watchdog expected done seen timeout");
      stop_test();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         wb(0, adr_tab[i], 16'h0000);
         chk("reset value", RST_REG, q);
         wb(1, adr_tab[i], 16'hFFFF);
         wb(0, adr_tab[i], 16'h0000);
         chk("readback", msk_tab[i], q);
         wb(1, adr_tab[i], 16'h0000);
      end
      for (int c = 0; c < 4; c++) begin
         wb(1, OFS_CTL2, 16'(c) << CHPS_LSB);
         wait_n(1);
         chk("chan enable", 16'(cnt_tab[c]), 16'(chan_enable_o));
      end
      // Split fill, three sequences per event
      wb(1, OFS_CTL2, 16'h000A);
      n_ev = 0;
      pulse(0);
      pulse(0);
      chk("early event", 16'h0000, 16'(n_ev));
      pulse(0);
      chk("event", 16'h0001, 16'(n_ev));
      chk("split addr", 16'h0008, 16'(buf_addr_o));
      wb(0, OFS_CTL2, 16'h0000);
      chk("fill half", 16'h0001, 16'(q[FILL_HALF_BIT]));
      pulse(1);
      pulse(1);
      chk("result addr", 16'h000A, 16'(buf_addr_o));
      // Sixteen sequences per event, linear fill
      wb(1, OFS_CTL2, 16'h003C);
      n_ev = 0;
      repeat (15) pulse(0);
      chk("no event", 16'h0000, 16'(n_ev));
      pulse(0);
      chk("event 16", 16'h0001, 16'(n_ev));
      chk("linear addr", 16'h0000, 16'(buf_addr_o));
      // Scan of inputs 1, 2 and 4, two sequences per event
      wb(1, OFS_CTL2, 16'h0404);
      wb(1, OFS_SCAN, 16'h0016);
      chk("scan first", 16'h0001, 16'(ch0_pos_o));
      pulse(0);
      chk("scan next", 16'h0002, 16'(ch0_pos_o));
      pulse(0);
      chk("scan restart", 16'h0001, 16'(ch0_pos_o));
      wb(1, OFS_CTL2, 16'h0400);
      wb(1, OFS_SCAN, 16'h1000);
      pulse(0);
      chk("low ref", 16'h0001, 16'(ch0_low_ref_o));
      // Alternate sampling with A and B selections
      wb(1, OFS_CTL2, 16'hA005);
      wb(1, OFS_CHS123, 16'h0500);
      wb(1, OFS_CHS0, 16'h8503);
      wait_n(1);
      chk("ch0 a", 16'h0003, 16'(ch0_pos_o));
      chk("ch0 neg a", 16'h0000, 16'(ch0_neg_o));
      chk("ch13 neg a", 16'h0000, 16'(ch13_neg_o));
      chk("reference", 16'h0005, 16'(reference_select_o));
      pulse(0);
      chk("sample b", 16'h0001, 16'(sample_b_o));
      chk("ch0 b", 16'h0005, 16'(ch0_pos_o));
      chk("ch0 neg b", 16'h0001, 16'(ch0_neg_o));
      chk("ch13 b", 16'h0001, 16'(ch13_pos_o));
      chk("ch13 neg b", 16'h0002, 16'(ch13_neg_o));
      chk("open pos", 16'h0001, 16'(ch23_pos_open_o));
      // Pin configuration and module disable
      wait_n(2);
      chk("analog read", 16'h0000, port_read_o);
      wb(1, OFS_PCFG, 16'h000F);
      wait_n(2);
      chk("digital read", 16'h000F, port_read_o);
      chk("mux ground", 16'h000F, mux_ground_o);
      @(posedge clk_i);
      module_disable_i <= 1'b1;
      wait_n(3);
      chk("disabled pins", 16'hFFFF, mux_ground_o);
      chk("disabled read", 16'hFFFF, port_read_o);
      @(posedge clk_i);
      module_disable_i <= 1'b0;
      // Conversion clock divider and internal source
      wb(1, OFS_CTL3, 16'h0003);
      wait_n(70);
      n_tick = 0;
      wait_n(40);
      chk("div 4", 16'h000A, 16'(n_tick));
      wb(1, OFS_CTL3, 16'h00FF);
      wait_n(70);
      n_tick = 0;
      wait_n(128);
      chk("div max", 16'h0002, 16'(n_tick));
      wb(1, OFS_CTL3, 16'h8003);
      wait_n(3);
      n_tick = 0;
      repeat (5) begin
         @(posedge clk_i);
         rc_tick_i <= 1'b1;
         @(posedge clk_i);
         rc_tick_i <= 1'b0;
      end
      wait_n(3);
      chk("rc ticks", 16'h0005, 16'(n_tick));
      // Auto-sample time of two internal conversion clock periods
      wb(1, OFS_CTL3, 16'h8203);
      n_end = 0;
      @(posedge clk_i);
      sample_start_i <= 1'b1;
      @(posedge clk_i);
      sample_start_i <= 1'b0;
      wait_n(4);
      chk("sample early", 16'h0000, 16'(n_end));
      repeat (2) begin
         @(posedge clk_i);
         rc_tick_i <= 1'b1;
         @(posedge clk_i);
         rc_tick_i <= 1'b0;
      end
      wait_n(5);
      chk("sample end", 16'h0001, 16'(n_end));
      // Mid-run reset returns buffer address and pins to reset state
      pulse(1);
      chk("addr before reset", 16'h0001, 16'(buf_addr_o));
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_n(1);
      chk("reset addr", 16'h0000, 16'(buf_addr_o));
      chk("reset pins", 16'h0000, mux_ground_o);
      wb(0, OFS_PCFG, 16'h0000);
      chk("reset pcfg", RST_REG, q);
      stop_test();
   end
endmodule : adc_sequence_config_tb
